// [hmc_map.svh]
`ifndef HMC_MAP_SVH
`define HMC_MAP_SVH

// Register byte offsets.
`define HMC_OFF_LSMODE 12'h000
`define HMC_OFF_CFG 12'h004
`define HMC_OFF_STAT 12'h008

// Field positions.
`define HMC_LSMODE_STOP_BIT 0
`define HMC_CFG_ITMR_LS_BIT 0
`define HMC_CFG_WDT_LS_BIT 1

// Reset values.
`define HMC_LSMODE_RST 1'h0
`define HMC_CFG_RST 2'h0

// Timing.
`define HMC_CLK_MHZ 125
`define HMC_WAKE_VEC_CYC 5'h0c
`define HMC_WAKE_NXT_CYC 5'h04
`define HMC_OPT_INT_NS 1075000
`define HMC_OPT_XTAL_NS 1074000

`endif

// [hmc_pkg.sv]
package hmc_pkg;

   typedef enum logic [1:0] {
      HMC_OPT_READ,
      HMC_RUN,
      HMC_HALT,
      HMC_WAKE
   } hmc_state_t;

   typedef logic [17:0] hmc_count_t;

endpackage : hmc_pkg

// [hmc_wait_timer.sv]
`timescale 1ns/1ps

// Down counter shared by the option-read hold and the wake-up wait.
module hmc_wait_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire hmc_pkg::hmc_count_t load_val,
   output logic done
);

   hmc_pkg::hmc_count_t cnt_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff <= 18'h00000;
      end
      else if (load)
      begin
         cnt_ff <= load_val;
      end
      else if (cnt_ff != 18'h00000)
      begin
         cnt_ff <= cnt_ff - 18'h00001;
      end
   end

   // Done fires in the last counted cycle so a load of N spans exactly N cycles.
   assign done = (cnt_ff == 18'h00001) && !load;

endmodule : hmc_wait_timer

// [hmc_halt_ctrl.sv]
// Function
// - Halt is entered only by the CPU halt instruction strobe.
// - A request already pending and unmasked at entry ends halt at once.
// - CPU clock is gated off in halt; system oscillator keeps running.
// - Port output latches hold their pre-halt value throughout halt.
// - The 16-bit timer clock stays on in halt in every configuration.
// - Interval timer on the divided peripheral clock keeps counting in halt.
// - Interval timer on the low-speed clock counts unless that oscillator is stopped.
// - Watchdog stops in halt on system clock; on low-speed, runs only if unstoppable.
// - Any unmasked interrupt request ends halt.
// - Wake takes the vector if global enable set, else resumes at next instruction.
// - Vectored wake waits eleven to thirteen cycles before servicing.
// - Non-vectored wake waits three to five cycles before resuming.
// - Reset ends halt and runs the normal reset sequence to the reset vector.
// - Internal or external clock: hold execution up to 1.075 ms after reset.
// - Crystal or ceramic clock: hold execution up to 1.074 ms after reset.
// - Halt entry and exit leave all registers and memory unchanged.
// - Low-speed stop bit stops the oscillator only when marked software-stoppable.
`timescale 1ns/1ps
`include "hmc_map.svh"

module hmc_halt_ctrl
#(
   parameter int OPT_INT_CYC = `HMC_OPT_INT_NS * `HMC_CLK_MHZ / 1000,
   parameter int OPT_XTAL_CYC = `HMC_OPT_XTAL_NS * `HMC_CLK_MHZ / 1000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_instr,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] interrupt_mask_flag,
   input wire logic global_interrupt_enable,
   input wire logic opt_crystal_clk,
   input wire logic opt_lowspeed_stoppable,
   input wire logic port_wr_en,
   input wire logic [7:0] port_wr_data,
   output logic [7:0] port_latch,
   output logic cpu_clk_en,
   output logic cpu_run,
   output logic vector_take,
   output logic resume_next,
   output logic sysosc_run,
   output logic lowspeed_osc_run,
   output logic tmr16_clk_en,
   output logic itmr_clk_en,
   output logic wdt_clk_en,
   output logic aux_run
);

   hmc_pkg::hmc_state_t state_ff;
   hmc_pkg::hmc_state_t nxt_state;
   logic first_ff;
   logic crystal_ff;
   logic stoppable_ff;
   logic vec_ff;
   logic lowspeed_osc_stop_bit_ff;
   logic [1:0] cfg_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [7:0] port_latch_ff;
   logic cpu_clk_en_ff;
   logic cpu_run_ff;
   logic vector_take_ff;
   logic resume_next_ff;
   logic lowspeed_run_ff;
   logic tmr16_en_ff;
   logic itmr_en_ff;
   logic wdt_en_ff;
   logic aux_run_ff;
   logic wake_req;
   logic halted;
   logic ls_running;
   logic tmr_load;
   hmc_pkg::hmc_count_t tmr_val;
   logic tmr_done;
   logic apb_wr;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == `HMC_OFF_LSMODE) || (a == `HMC_OFF_CFG) || (a == `HMC_OFF_STAT);
   endfunction : addr_known

   function automatic hmc_pkg::hmc_count_t to_count(input int cyc);
      to_count = hmc_pkg::hmc_count_t'(cyc);
   endfunction : to_count

   // Only unmasked requests count; global enable plays no part here.
   assign wake_req = |(irq_req & ~interrupt_mask_flag);
   assign halted = (state_ff == hmc_pkg::HMC_HALT);
   // The stop bit has no effect unless the option marks the oscillator stoppable.
   assign ls_running = !(stoppable_ff && lowspeed_osc_stop_bit_ff);
   assign apb_wr = psel && penable && pready_ff && pwrite;

   always_comb
   begin
      nxt_state = state_ff;
      tmr_load = 1'b0;
      tmr_val = 18'h00000;
      case (state_ff)
         hmc_pkg::HMC_OPT_READ:
         begin
            // The hold length depends on the clock source strap seen in the first cycle.
            if (first_ff)
            begin
               tmr_load = 1'b1;
               tmr_val = opt_crystal_clk ? to_count(OPT_XTAL_CYC) : to_count(OPT_INT_CYC);
            end
            else if (tmr_done)
            begin
               nxt_state = hmc_pkg::HMC_RUN;
            end
         end
         hmc_pkg::HMC_RUN:
         begin
            if (halt_instr)
            begin
               nxt_state = hmc_pkg::HMC_HALT;
            end
         end
         hmc_pkg::HMC_HALT:
         begin
            // A request pending at entry is seen in the first halted cycle.
            if (wake_req)
            begin
               nxt_state = hmc_pkg::HMC_WAKE;
               tmr_load = 1'b1;
               tmr_val = global_interrupt_enable ? {13'h0000, `HMC_WAKE_VEC_CYC}
                                                 : {13'h0000, `HMC_WAKE_NXT_CYC};
            end
         end
         hmc_pkg::HMC_WAKE:
         begin
            if (tmr_done)
            begin
               nxt_state = hmc_pkg::HMC_RUN;
            end
         end
         default:
         begin
            nxt_state = hmc_pkg::HMC_OPT_READ;
         end
      endcase
   end

   hmc_wait_timer u_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= hmc_pkg::HMC_OPT_READ;
         first_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         first_ff <= 1'b0;
      end
   end

   // Option straps are caught once after reset release, never under the reset itself.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crystal_ff <= 1'b0;
         stoppable_ff <= 1'b0;
      end
      else if (first_ff)
      begin
         crystal_ff <= opt_crystal_clk;
         stoppable_ff <= opt_lowspeed_stoppable;
      end
   end

   // The vector decision is frozen at wake so a late enable change cannot split it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vec_ff <= 1'b0;
      end
      else if (halted && wake_req)
      begin
         vec_ff <= global_interrupt_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_take_ff <= 1'b0;
         resume_next_ff <= 1'b0;
      end
      else
      begin
         vector_take_ff <= (state_ff == hmc_pkg::HMC_WAKE) && tmr_done && vec_ff;
         resume_next_ff <= (state_ff == hmc_pkg::HMC_WAKE) && tmr_done && !vec_ff;
      end
   end

   // The CPU clock returns during the wake wait; execution waits for the wait to end.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_clk_en_ff <= 1'b1;
         cpu_run_ff <= 1'b0;
      end
      else
      begin
         cpu_clk_en_ff <= (nxt_state != hmc_pkg::HMC_HALT);
         cpu_run_ff <= (nxt_state == hmc_pkg::HMC_RUN);
      end
   end

   // Halt changes no stored state; only writes while running reach the latch.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_latch_ff <= 8'h00;
      end
      else if (port_wr_en && (state_ff == hmc_pkg::HMC_RUN))
      begin
         port_latch_ff <= port_wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lowspeed_run_ff <= 1'b1;
         tmr16_en_ff <= 1'b1;
         itmr_en_ff <= 1'b1;
         wdt_en_ff <= 1'b0;
         aux_run_ff <= 1'b1;
      end
      else
      begin
         lowspeed_run_ff <= ls_running;
         tmr16_en_ff <= 1'b1;
         itmr_en_ff <= cfg_ff[`HMC_CFG_ITMR_LS_BIT] ? ls_running : 1'b1;
         if (halted)
         begin
            wdt_en_ff <= cfg_ff[`HMC_CFG_WDT_LS_BIT] && !stoppable_ff;
         end
         else
         begin
            wdt_en_ff <= cfg_ff[`HMC_CFG_WDT_LS_BIT] ? ls_running : (state_ff != hmc_pkg::HMC_OPT_READ);
         end
         aux_run_ff <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lowspeed_osc_stop_bit_ff <= `HMC_LSMODE_RST;
         cfg_ff <= `HMC_CFG_RST;
      end
      else if (apb_wr && (paddr == `HMC_OFF_LSMODE))
      begin
         lowspeed_osc_stop_bit_ff <= pwdata[`HMC_LSMODE_STOP_BIT];
      end
      else if (apb_wr && (paddr == `HMC_OFF_CFG))
      begin
         cfg_ff <= pwdata[1:0];
      end
   end

   // Every access completes on its first access cycle, so pready is set in setup.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end
      else
      begin
         pready_ff <= psel && !penable;
         pslverr_ff <= psel && !penable && !addr_known(paddr);
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               `HMC_OFF_LSMODE: prdata_ff <= {31'h00000000, lowspeed_osc_stop_bit_ff};
               `HMC_OFF_CFG: prdata_ff <= {30'h00000000, cfg_ff};
               `HMC_OFF_STAT: prdata_ff <= {22'h000000, vec_ff, stoppable_ff, crystal_ff,
                                            lowspeed_run_ff, wdt_en_ff, itmr_en_ff,
                                            cpu_run_ff, cpu_clk_en_ff, state_ff};
               default: prdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign port_latch = port_latch_ff;
   assign cpu_clk_en = cpu_clk_en_ff;
   assign cpu_run = cpu_run_ff;
   assign vector_take = vector_take_ff;
   assign resume_next = resume_next_ff;
   // The system oscillator is never stopped by this block.
   assign sysosc_run = aux_run_ff;
   assign lowspeed_osc_run = lowspeed_run_ff;
   assign tmr16_clk_en = tmr16_en_ff;
   assign itmr_clk_en = itmr_en_ff;
   assign wdt_clk_en = wdt_en_ff;
   assign aux_run = aux_run_ff;

endmodule : hmc_halt_ctrl

// [hmc_halt_ctrl_asserts.sv]
`timescale 1ns/1ps

module hmc_halt_ctrl_asserts
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt_instr,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] interrupt_mask_flag,
   input wire logic global_interrupt_enable,
   input wire logic opt_lowspeed_stoppable,
   input wire logic [7:0] port_latch,
   input wire logic cpu_clk_en,
   input wire logic cpu_run,
   input wire logic vector_take,
   input wire logic resume_next,
   input wire logic sysosc_run,
   input wire logic tmr16_clk_en,
   input wire logic wdt_clk_en,
   input wire logic aux_run,
   input wire logic pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   halt_entry_a: assert property (cpu_run && halt_instr |=> !cpu_clk_en && !cpu_run)
      else $error("cpu clock not gated after halt");
   entry_cause_a: assert property ($fell(cpu_clk_en) |-> $past(halt_instr) && $past(cpu_run))
      else $error("cpu clock gated without halt");
   osc_on_a: assert property (sysosc_run && tmr16_clk_en && aux_run)
      else $error("always-on clock dropped");
   latch_hold_a: assert property (!cpu_clk_en |=> port_latch == $past(port_latch))
      else $error("port latch changed in halt");
   masked_hold_a: assert property (!cpu_clk_en && (irq_req & ~interrupt_mask_flag) == 8'h00 |=> !cpu_clk_en)
      else $error("halt left without unmasked request");
   wake_req_a: assert property (!cpu_clk_en && (irq_req & ~interrupt_mask_flag) != 8'h00 |=> cpu_clk_en)
      else $error("unmasked request did not wake");
   vec_wait_a: assert property ($rose(cpu_clk_en) && $past(global_interrupt_enable)
      |-> !cpu_run ##[10:12] vector_take && cpu_run)
      else $error("vectored wake wait wrong");
   next_wait_a: assert property ($rose(cpu_clk_en) && !$past(global_interrupt_enable)
      |-> ##[2:4] resume_next && cpu_run)
      else $error("plain wake wait wrong");
   wdt_halt_a: assert property (!cpu_clk_en && !$past(cpu_clk_en) && opt_lowspeed_stoppable |-> !wdt_clk_en)
      else $error("watchdog ran in halt");

   cover property (vector_take);
   cover property (resume_next);
   cover property (pslverr);
endmodule : hmc_halt_ctrl_asserts

bind hmc_halt_ctrl hmc_halt_ctrl_asserts i_chk (.pclk, .presetn, .halt_instr, .irq_req, .interrupt_mask_flag,
   .global_interrupt_enable, .opt_lowspeed_stoppable, .port_latch, .cpu_clk_en, .cpu_run, .vector_take,
   .resume_next, .sysosc_run, .tmr16_clk_en, .wdt_clk_en, .aux_run, .pslverr);

// [hmc_irq_src.sv]
`timescale 1ns/1ps

module hmc_irq_src
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] set_req,
   input wire logic vector_take,
   input wire logic resume_next,
   output logic [7:0] irq_req
);
   logic [7:0] irq_ff;

   // Flags stay up until the core acts on a wake, so a masked request keeps waiting.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq_ff <= 8'h00;
      else if (vector_take || resume_next)
         irq_ff <= set_req;
      else
         irq_ff <= irq_ff | set_req;

   assign irq_req = irq_ff;
endmodule : hmc_irq_src

// [hmc_halt_ctrl_tb_top.sv]
`timescale 1ns/1ps

module hmc_halt_ctrl_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_instr, global_interrupt_enable;
   logic opt_crystal_clk, opt_lowspeed_stoppable, port_wr_en, cpu_clk_en, cpu_run, vector_take, resume_next;
   logic sysosc_run, lowspeed_osc_run, tmr16_clk_en, itmr_clk_en, wdt_clk_en, aux_run, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] irq_req, interrupt_mask_flag, set_req, port_wr_data, port_latch;
   int n_fail, n_tests, n;

   hmc_halt_ctrl #(.OPT_INT_CYC(20), .OPT_XTAL_CYC(19)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .halt_instr, .irq_req, .interrupt_mask_flag,
      .global_interrupt_enable, .opt_crystal_clk, .opt_lowspeed_stoppable, .port_wr_en, .port_wr_data,
      .port_latch, .cpu_clk_en, .cpu_run, .vector_take, .resume_next, .sysosc_run, .lowspeed_osc_run,
      .tmr16_clk_en, .itmr_clk_en, .wdt_clk_en, .aux_run);
   hmc_irq_src i_src (.pclk, .presetn, .set_req, .vector_take, .resume_next, .irq_req);

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         n_fail++;
         finish_test();
      end
   endtask : apb

   task pulse_halt;
      @(posedge pclk);
      halt_instr <= 1'b1;
      @(posedge pclk);
      halt_instr <= 1'b0;
      #1 chk("cpu_clk_en", 32'h0, cpu_clk_en);
   endtask : pulse_halt

   task raise(input logic [7:0] v);
      @(posedge pclk);
      set_req <= v;
      @(posedge pclk);
      set_req <= 8'h00;
   endtask : raise

   task wake(input logic vec);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (vector_take !== 1'b1 && resume_next !== 1'b1 && n < 30);
      if (n == 30)
      begin
         n_fail++;
         finish_test();
      end
      chk("vector_take", {31'h0, vec}, vector_take);
      chk("resume_next", {31'h0, !vec}, resume_next);
   endtask : wake

   task opt_wait(input int lo);
      n = 0;
      while (cpu_run !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      chk("option hold", 32'h1, (n >= lo && n <= lo + 2));
   endtask : opt_wait

   initial
   begin
      {presetn, psel, penable, pwrite, halt_instr, global_interrupt_enable, port_wr_en} = '0;
      {paddr, pwdata, port_wr_data, set_req, opt_crystal_clk} = '0;
      opt_lowspeed_stoppable = 1'b1;
      interrupt_mask_flag = 8'hff;
      n_fail = 0;
      n_tests = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      opt_wait(20);
      apb(1'b0, 12'h004, 32'h0);
      chk("cfg reset", 32'h0, rd);
      apb(1'b1, 12'h004, 32'h3);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk("lsmode", 32'h1, rd);
      chk("lowspeed_osc_run", 32'h0, lowspeed_osc_run);
      chk("itmr_clk_en", 32'h0, itmr_clk_en);
      apb(1'b1, 12'h00c, 32'h5);
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      @(posedge pclk);
      port_wr_en <= 1'b1;
      port_wr_data <= 8'ha5;
      @(posedge pclk);
      port_wr_en <= 1'b0;
      pulse_halt();
      raise(8'h04);
      port_wr_en <= 1'b1;
      port_wr_data <= 8'h3c;
      @(posedge pclk);
      port_wr_en <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("masked halt", 32'h0, cpu_clk_en);
      chk("port_latch", 32'ha5, port_latch);
      chk("wdt_clk_en", 32'h0, wdt_clk_en);
      chk("timers on", 32'h1, tmr16_clk_en & sysosc_run & aux_run);
      global_interrupt_enable <= 1'b1;
      interrupt_mask_flag <= 8'hfb;
      wake(1'b1);
      apb(1'b1, 12'h004, 32'h2);
      repeat (2) @(posedge pclk);
      chk("itmr peripheral clock", 32'h1, itmr_clk_en);
      apb(1'b1, 12'h004, 32'h3);
      apb(1'b1, 12'h000, 32'h0);
      repeat (2) @(posedge pclk);
      chk("itmr running", 32'h1, itmr_clk_en);
      chk("lowspeed_osc_run on", 32'h1, lowspeed_osc_run);
      global_interrupt_enable <= 1'b0;
      pulse_halt();
      raise(8'h04);
      wake(1'b0);
      raise(8'h04);
      pulse_halt();
      wake(1'b0);
      pulse_halt();
      opt_crystal_clk <= 1'b1;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk("cpu_run in reset", 32'h0, {port_latch, cpu_run});
      opt_wait(19);
      finish_test();
   end
endmodule : hmc_halt_ctrl_tb_top
